// file: src/can_gc_pkg.sv
// package for the CAN global control block: register layout, reset values, timing
// assumes an 8-bit special-function register port from the core
package can_gc_pkg;
	localparam logic [7:0] GCON_ADDR      = 8'hAB;
	localparam logic [7:0] GSTA_ADDR      = 8'hAA;
	localparam logic [7:0] GCON_RESET     = 8'h00;
	localparam int         BIT_ABORT      = 7;
	localparam int         BIT_OVERLOAD   = 6;
	localparam int         BIT_TTC        = 5;
	localparam int         BIT_SYNC_EOF   = 4;
	localparam int         BIT_LISTEN     = 3;
	localparam int         BIT_TEST       = 2;
	localparam int         BIT_ENABLE     = 1;
	localparam int         BIT_GENERAL_SOFT_RESET       = 0;
	localparam int         BIT_ENABLE_STATE_FLAG       = 2;
	localparam int         BIT_OVFG       = 6;
	localparam logic [1:0] START_CYCLES   = 2'd2;
	localparam int         NUM_OBJECTS    = 15;

	typedef enum logic [1:0]
	{
		ST_OFF      = 2'b00,
		ST_STARTING = 2'b01,
		ST_ON       = 2'b11,
		ST_STOPPING = 2'b10
	} run_state_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed
	{
		logic frame_active;
		logic rx_msg_done;
		logic ovl_start;
		logic ovl_active;
		logic sof;
		logic eof_last;
	} engine_evt_t;

	typedef struct packed
	{
		logic run;
		logic listen_only;
		logic abort_pending;
		logic ovl_request;
		logic ttc_on;
		logic test_mode;
		logic soft_reset;
		logic freeze_err_cnt;
		logic capture_timer;
	} engine_ctl_t;
endpackage

// file: src/can_gc_run.sv
// enable/standby sequencer: start delay, frame-safe stop, clock gate request
// assumes engine frame_active comes from logic on clk
`timescale 1ns/1ps
module can_gc_run
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic enable_bit,
	input  wire logic frame_active,
	output logic      running,
	output logic      clock_on
);
	import can_gc_pkg::*;

	run_state_t state;
	run_state_t next_state;
	logic [1:0] cnt;
	wire        cnt_done = (cnt == START_CYCLES - 2'd1);

	always_comb
	begin
		next_state = state;
		case (state)
			ST_OFF:      if (enable_bit) next_state = ST_STARTING;
			ST_STARTING: if (!enable_bit) next_state = ST_OFF;
			             else if (cnt_done) next_state = ST_ON;
			ST_ON:       if (!enable_bit) next_state = ST_STOPPING;
			ST_STOPPING: if (enable_bit) next_state = ST_ON;
			             else if (!frame_active) next_state = ST_OFF;
			default:     next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state    <= ST_OFF;
			cnt      <= 2'd0;
			running  <= 1'b0;
			clock_on <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			// R13 two-period start
			cnt      <= (state == ST_STARTING) ? cnt + 2'd1 : 2'd0;
			running  <= (next_state == ST_ON) || (next_state == ST_STOPPING);
			// R9 clock on with enable
			clock_on <= (next_state != ST_OFF);
		end
	end
endmodule

// file: src/can_global_control.sv
// CAN global control register and its effects on the protocol engine
// assumes an 8-bit SFR port on clk and engine event pulses on clk
// Function
// R1: abort clears all object enables; abort bit stays until software clears it
// R2: abort drops pending transmits; a frame in progress completes normally
// R3: overload request sends overload frame after next received message
// R4: hardware clears overload request when overload frame transmission begins
// R5: time-triggered select enables time-triggered features; clear disables them
// R6: timer capture at last EOF bit or at SOF, only in time-triggered mode
// R7: listen-only mode: no ack, no transmit, error flags update, counters frozen
// R8: test mode bit is reserved for factory use; software leaves it clear
// R9: enable bit switches on controller and its input clock
// R10: disable lets current frame finish, then freezes; object enables kept
// R11: standby holds transmit recessive, receiver off, clock stopped
// R12: registers and mailbox stay accessible while disabled
// R13: controller starts two clock periods after enabling
// R14: read-only enable-state flag reports the mode actually in force
// R15: general reset resets controller; bit self-clears and reads zero
`timescale 1ns/1ps
module can_global_control
(
	input  wire logic                          clk,
	input  wire logic                          srst,
	input  wire can_gc_pkg::sfr_req_t          sfr,
	input  wire can_gc_pkg::engine_evt_t       evt,
	input  wire logic                          engine_tx,
	input  wire logic                          rx_pin,
	input  wire logic [can_gc_pkg::NUM_OBJECTS-1:0] obj_en_set,
	input  wire logic [can_gc_pkg::NUM_OBJECTS-1:0] obj_en_clr,
	output logic [7:0]                         rdata,
	output can_gc_pkg::engine_ctl_t            ctl,
	output logic [can_gc_pkg::NUM_OBJECTS-1:0] object_enable,
	output logic                               tx_pin,
	output logic                               rx_active,
	output logic                               engine_clk_en
);
	import can_gc_pkg::*;

	logic [7:0] gcon;
	logic [7:0] next_gcon;
	logic       rx_meta;
	logic       rx_sync;
	logic       ovl_armed;
	logic       running;
	logic       clock_on;

	// decode
	wire wr_gcon = sfr.wr && (sfr.addr == GCON_ADDR);
	wire rd_gcon = sfr.rd && (sfr.addr == GCON_ADDR);
	wire rd_gsta = sfr.rd && (sfr.addr == GSTA_ADDR);
	wire abort_on    = gcon[BIT_ABORT];
	wire ovl_on      = gcon[BIT_OVERLOAD];
	wire ttc_on      = gcon[BIT_TTC];
	wire sync_eof_on = gcon[BIT_SYNC_EOF];
	wire listen_on   = gcon[BIT_LISTEN];
	wire test_on     = gcon[BIT_TEST];
	wire enable_on   = gcon[BIT_ENABLE];
	wire general_soft_reset_on     = gcon[BIT_GENERAL_SOFT_RESET];
	// R14 enable-state flag shows the sequencer, not the bit
	wire [7:0] ovl_flag_view = 8'(evt.ovl_active) << BIT_OVFG;
	wire [7:0] run_flag_view = 8'(running) << BIT_ENABLE_STATE_FLAG;
	wire [7:0] gsta_view     = ovl_flag_view | run_flag_view;
	// a dominant line counts as traffic, so standby waits for an idle bus
	wire line_busy = evt.frame_active || !rx_sync;
	// R15 reset bit reads back zero
	wire [7:0] gcon_view = {gcon[7:1], 1'b0};
	wire [7:0] next_rdata = rd_gcon ? gcon_view : (rd_gsta ? gsta_view : 8'h00);
	wire ovl_begins = evt.ovl_start && gcon[BIT_OVERLOAD];

	always_comb
	begin
		next_gcon = wr_gcon ? sfr.wdata : gcon;
		// R4 self-clear at overload start, wins over write
		if (ovl_begins)
			next_gcon[BIT_OVERLOAD] = 1'b0;
		// R15 one-cycle reset pulse
		if (gcon[BIT_GENERAL_SOFT_RESET] && !wr_gcon)
			next_gcon[BIT_GENERAL_SOFT_RESET] = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			gcon <= GCON_RESET;
		else
			gcon <= next_gcon;
	end

	// R12 register port works regardless of enable
	always_ff @(posedge clk)
	begin
		if (srst)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end
		else
		begin
			rx_meta <= rx_pin;
			rx_sync <= rx_meta;
		end
	end

	// R3 arm after the next received message
	always_ff @(posedge clk)
	begin
		if (srst || !gcon[BIT_OVERLOAD])
			ovl_armed <= 1'b0;
		else if (evt.rx_msg_done)
			ovl_armed <= 1'b1;
	end

	can_gc_run u_run
	(
		.clk          (clk),
		.srst         (srst || general_soft_reset_on),
		.enable_bit   (enable_on),
		.frame_active (line_busy),
		.running      (running),
		.clock_on     (clock_on)
	);

	genvar i;
	generate
		for (i = 0; i < NUM_OBJECTS; i++)
		begin : g_obj
			always_ff @(posedge clk)
			begin
				if (srst)
					object_enable[i] <= 1'b0;
				// R1 abort clears every object enable
				else if (abort_on)
					object_enable[i] <= 1'b0;
				else if (obj_en_set[i])
					object_enable[i] <= 1'b1;
				// R10 engine clears only while running
				else if (obj_en_clr[i] && running)
					object_enable[i] <= 1'b0;
			end
		end
	endgenerate

	// next values of the registered outputs
	wire next_run            = running;
	wire next_listen_only    = listen_on;
	wire next_freeze_err_cnt = listen_on;
	wire next_abort_pending  = abort_on;
	wire next_ovl_request    = ovl_armed && ovl_on;
	wire next_ttc_on         = ttc_on;
	wire capture_event       = sync_eof_on ? evt.eof_last : evt.sof;
	wire next_capture_timer  = ttc_on && capture_event;
	wire next_test_mode      = test_on;
	wire next_soft_reset     = general_soft_reset_on;
	wire next_tx_pin         = (running && !listen_on) ? engine_tx : 1'b1;
	wire next_rx_active      = running;
	wire next_engine_clk_en  = clock_on;

	// R10 freeze engine when stopped
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.run <= 1'b0;
		else
			ctl.run <= next_run;
	end

	// R7 listen-only monitoring
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.listen_only <= 1'b0;
		else
			ctl.listen_only <= next_listen_only;
	end

	// R7 error counters frozen
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.freeze_err_cnt <= 1'b0;
		else
			ctl.freeze_err_cnt <= next_freeze_err_cnt;
	end

	// R2 drop pending transmissions
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.abort_pending <= 1'b0;
		else
			ctl.abort_pending <= next_abort_pending;
	end

	// R3 overload after next message
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.ovl_request <= 1'b0;
		else
			ctl.ovl_request <= next_ovl_request;
	end

	// R5 time-triggered enable
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.ttc_on <= 1'b0;
		else
			ctl.ttc_on <= next_ttc_on;
	end

	// R6 capture point select
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.capture_timer <= 1'b0;
		else
			ctl.capture_timer <= next_capture_timer;
	end

	// test bit passed through only
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.test_mode <= 1'b0;
		else
			ctl.test_mode <= next_test_mode;
	end

	// R15 engine reset pulse
	always_ff @(posedge clk)
	begin
		if (srst)
			ctl.soft_reset <= 1'b0;
		else
			ctl.soft_reset <= next_soft_reset;
	end

	// R11 R7 recessive in standby or listen-only
	always_ff @(posedge clk)
	begin
		if (srst)
			tx_pin <= 1'b1;
		else
			tx_pin <= next_tx_pin;
	end

	// R11 receiver off in standby
	always_ff @(posedge clk)
	begin
		if (srst)
			rx_active <= 1'b0;
		else
			rx_active <= next_rx_active;
	end

	// R9 R11 gate engine clock
	always_ff @(posedge clk)
	begin
		if (srst)
			engine_clk_en <= 1'b0;
		else
			engine_clk_en <= next_engine_clk_en;
	end
endmodule

// file: bench/can_gc_checker.sv
// port checker for can_global_control
// assumes the design's own ports only
`timescale 1ns/1ps
module can_gc_checker
(
	input wire logic	clk,
	input wire logic	srst,
	input wire can_gc_pkg::sfr_req_t	sfr,
	input wire can_gc_pkg::engine_evt_t	evt,
	input wire logic [7:0]	rdata,
	input wire can_gc_pkg::engine_ctl_t	ctl,
	input wire logic [14:0]	object_enable,
	input wire logic	tx_pin,
	input wire logic	rx_active,
	input wire logic	engine_clk_en
);
	import can_gc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire gw = sfr.wr && sfr.addr == GCON_ADDR;
	wire gr = sfr.rd && sfr.addr == GCON_ADDR;
	abort_clear_a: assert property (gw && sfr.wdata[7] |-> ##[1:3] object_enable == '0)
		else $error("abort");
	ovl_clear_a: assert property (evt.ovl_start |-> ##[1:2] !ctl.ovl_request)
		else $error("overload");
	ttc_off_a: assert property ((!ctl.ttc_on)[*2] |-> !ctl.capture_timer)
		else $error("capture");
	listen_only_a: assert property (ctl.listen_only[*2] |-> tx_pin && ctl.freeze_err_cnt)
		else $error("listen");
	start_delay_a: assert property ($rose(engine_clk_en) |-> !ctl.run ##[1:3] ctl.run)
		else $error("start");
	standby_io_a: assert property ((!engine_clk_en)[*2] |-> tx_pin && !rx_active)
		else $error("standby");
	general_soft_reset_zero_a: assert property (gr |=> !rdata[0])
		else $error("general_soft_reset");
	general_soft_reset_pulse_a: assert property (ctl.soft_reset |=> !ctl.soft_reset)
		else $error("pulse");
	cover property (gw && sfr.wdata[7]);
	cover property ($rose(ctl.run));
	cover property (evt.ovl_start);
endmodule
bind can_global_control can_gc_checker chk_u (.clk(clk), .srst(srst), .sfr(sfr), .evt(evt),
	.rdata(rdata), .ctl(ctl), .object_enable(object_enable), .tx_pin(tx_pin),
	.rx_active(rx_active), .engine_clk_en(engine_clk_en));

// file: bench/can_node_model.sv
// other bus nodes: one 20-cycle received frame per go pulse
// assumes go comes only while the bus is idle
`timescale 1ns/1ps
module can_node_model
(
	input wire logic	clk,
	input wire logic	go,
	input wire logic	ovl_req,
	output can_gc_pkg::engine_evt_t	evt,
	output logic	rx_pin
);
	logic [4:0] n = 5'h00;
	always @(posedge clk)
		n <= go ? 5'h14 : n - 5'(n != 5'h00);
	// recessive when idle, toggling bits inside a frame
	assign rx_pin = n == 5'h00 || n[0];
	// overload frame starts and is shown as sent while the request stands on an idle bus
	wire ovl_now = ovl_req && n == 5'h00;
	assign evt = '{n != 5'h00, n == 5'h01, ovl_now, ovl_now, n == 5'h13, n == 5'h02};
endmodule

// file: bench/can_global_control_tb_top.sv
// self-checking bench for can_global_control
// assumes can_node_model on the bus side
`timescale 1ns/1ps
module can_global_control_tb_top;
	import can_gc_pkg::*;
	logic	clk = 0, srst = 1, go = 0;
	sfr_req_t	sfr = '0;
	engine_evt_t	evt;
	engine_ctl_t	ctl;
	logic	rx_pin, tx_pin, rx_act, clk_en;
	logic [14:0]	oset = '0, oclr = '0, oen;
	logic [7:0]	rdata;
	int	err_total = 0, checks_done = 0, cyc = 0;
	always #20 clk = ~clk;
	can_node_model node_u (.clk(clk), .go(go), .ovl_req(ctl.ovl_request), .evt(evt),
		.rx_pin(rx_pin));
	can_global_control dut_u (.clk(clk), .srst(srst), .sfr(sfr), .evt(evt), .engine_tx(1'b0),
		.rx_pin(rx_pin), .obj_en_set(oset), .obj_en_clr(oclr), .rdata(rdata), .ctl(ctl),
		.object_enable(oen), .tx_pin(tx_pin), .rx_active(rx_act), .engine_clk_en(clk_en));
	task automatic chk(input logic [17:0] g, e);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge clk) sfr = '{1'b1, 1'b0, GCON_ADDR, d};
		@(negedge clk) sfr.wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(negedge clk) sfr = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk) sfr.rd = 0;
		chk(rdata, e);
	endtask
	// f: start a bus frame, else set every object enable
	task automatic kick(input logic f);
		@(negedge clk) {go, oset} = {f, {15{!f}}};
		@(negedge clk) {go, oset} = '0;
	endtask
	task automatic t_setup;
		rd(GCON_ADDR, GCON_RESET);
		wr(8'h19);
		rd(GCON_ADDR, 8'h18);
		wr(8'h22);
		chk(ctl.run, 1'b0);
		repeat (4) @(negedge clk);
		chk({ctl.run, ctl.ttc_on, clk_en, tx_pin, ctl.test_mode}, 5'h1C);
		rd(GSTA_ADDR, 8'h04);
	endtask
	task automatic t_abort;
		kick(0);
		chk(oen, 15'h7FFF);
		wr(8'h82);
		kick(0);
		chk({oen, ctl.abort_pending}, {15'h0000, 1'b1});
		rd(GCON_ADDR, 8'h82);
	endtask
	task automatic t_overload;
		wr(8'h42);
		kick(1);
		chk(ctl.ovl_request, 1'b0);
		repeat (21) @(negedge clk);
		chk(ctl.ovl_request, 1'b1);
		rd(GSTA_ADDR, 8'h44);
		rd(GCON_ADDR, 8'h02);
	endtask
	task automatic t_disable;
		kick(0);
		kick(1);
		wr(8'h00);
		rd(GSTA_ADDR, 8'h04);
		repeat (25) @(negedge clk);
		rd(GSTA_ADDR, 8'h00);
		@(negedge clk) oclr = 15'h7FFF;
		@(negedge clk) oclr = '0;
		chk({oen, tx_pin, rx_act, clk_en}, {15'h7FFF, 3'b100});
	endtask
	// one frame, capture pulse expected only at negedge number hit
	task automatic scan(input int hit);
		kick(1);
		for (int k = 2; k < 24; k++)
		begin
			@(negedge clk);
			chk(ctl.capture_timer, k == hit);
		end
	endtask
	task automatic t_ttc;
		wr(8'h32);
		scan(20);
		wr(8'h22);
		scan(3);
		wr(8'h12);
		scan(0);
		chk(ctl.ttc_on, 1'b0);
	endtask
	task automatic t_listen;
		wr(8'h0A);
		kick(1);
		repeat (6) @(negedge clk);
		chk({tx_pin, ctl.freeze_err_cnt, ctl.listen_only}, 3'h7);
		@(negedge clk) oclr = 15'h0001;
		@(negedge clk) oclr = '0;
		chk(oen, 15'h7FFE);
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge clk);
		srst = 0;
		t_setup;
		t_abort;
		t_overload;
		t_disable;
		t_ttc;
		t_listen;
		final_report;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			final_report;
		end
	end
endmodule
